// [design/ctr_channel_trip_ramp.sv]
// What this block does
// R1: Switch-off or lower setpoint moves output down no faster than ramp-down rate.
// R2: Power setting off brings output to zero at ramp-down rate.
// R3: Trip with 0<limit<1000 and ramp style ramps output to zero.
// R4: Front-panel output disable ramps output to zero at ramp-down rate.
// R5: Trip limit 1000 means constant current, overcurrent never switches off.
// R6: Programmable protection lowers voltage to keep current below selected limit.
// R7: Fixed protection lets current exceed setting; no voltage regulation here.
// R8: Trip mode holds constant current for trip interval then switches off.
// R9: Kill style drops a tripped channel at once, ignoring ramp rate.
// R10: Trip counter reloads on limit write, alarm clear, power-on, overcurrent end.
// R11: Trip counter counts only during overcurrent; expiry causes the trip.
// R12: Channel turns on only with power set, no inhibit, outputs enabled.
// R13: Turn-on ramps from zero to the selected setpoint at ramp-up rate.
// R14: Writing power on clears alarms and reloads the trip counter.
// R15: Restore enabled: startup returns the saved power state.
// R16: Restore disabled: every channel starts off.
// R17: Shutdown style applies only to trip power-offs.
// R18: Voltage select low uses first setpoint, high uses second.
// R19: Current select low uses first limit, high uses second.
// R20: Rising output moves no faster than ramp-up rate.
// R21: Trip counter decrements once per fixed tick from the system clock.
// R22: Ramping steps an internal setpoint toward its target each tick.
// R23: Tripped flag sets at expiry, stays until alarm clear or power-on write.
`timescale 1ns/100ps
`default_nettype none

module ctr_channel_trip_ramp #(
    parameter int VW = 24,
    parameter int TICK_CYCLES = ctr_pkg::TICK_CYCLES
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic externalInhibit,
    input wire logic outputEnable,
    input wire logic voltageSetpointSelect,
    input wire logic currentLimitSelect,
    input wire logic [VW-1:0] voltageReadback,
    input wire logic [15:0] currentReadback,
    input wire logic savedPowerSetting,
    input wire logic savedRestoreOnStartup,
    output logic [VW-1:0] outputSetpoint,
    output logic [15:0] activeCurrentLimit,
    output logic channelOn,
    output logic tripped,
    output logic powerSettingToSave,
    output logic restoreToSave
);

    // Elaboration checks: the step adder and the 32-bit register words assume these ranges.
    if (VW < 17 || VW > 32) begin : gBadWidth
        $error("VW must lie in 17..32");
    end
    if (TICK_CYCLES < 2) begin : gBadTick
        $error("TICK_CYCLES must be at least 2");
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Byte-lane merge for Wishbone writes.
    function automatic logic [31:0] wbMerge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) r[b*8 +: 8] = wd[b*8 +: 8];
        end
        return r;
    endfunction

    // Trip mode is any limit strictly between zero and the constant-current value.
    function automatic logic isTripMode(input logic [9:0] lim);
        return (lim != 10'h000) && (lim < ctr_pkg::TRIP_CONSTANT_CURRENT);
    endfunction

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [3:0] syncFirst;
    logic [3:0] syncSecond;
    logic inhibitActive;
    logic enableActive;
    logic vselActive;
    logic iselActive;

    // Pins are asynchronous; the first stage feeds only the second.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            syncFirst <= 4'h0;
            syncSecond <= 4'h0;
        end else begin
            syncFirst <= {currentLimitSelect, voltageSetpointSelect, outputEnable, externalInhibit};
            syncSecond <= syncFirst;
        end
    end
    assign inhibitActive = syncSecond[0];
    assign enableActive = syncSecond[1];
    assign vselActive = syncSecond[2];
    assign iselActive = syncSecond[3];

    // ------------------------------------------------------------
    // Registers and bus decode
    // ------------------------------------------------------------
    logic powerSetting;
    logic restoreOn;
    logic styleRamp;
    logic progProtection;
    logic [VW-1:0] vset0;
    logic [VW-1:0] vset1;
    logic [15:0] ilim0;
    logic [15:0] ilim1;
    logic [15:0] currentSetting;
    logic [15:0] rampUp;
    logic [15:0] rampDown;
    logic [9:0] tripLimit;
    logic startupPending;
    logic busTake;
    logic wrCtl;
    logic wrTrip;
    logic powerOnWrite;
    logic alarmClear;
    logic [31:0] ctlWord;
    logic [31:0] rdWord;
    logic [31:0] wrWord;
    logic overCurrent;
    logic tripExpire;
    logic killHold;
    logic ramping;

    assign busTake = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wrCtl = busTake && wb_we_i && wb_adr_i == ctr_pkg::OFS_CONTROL;
    assign wrTrip = busTake && wb_we_i && wb_adr_i == ctr_pkg::OFS_TRIP_LIMIT;
    assign ctlWord = wbMerge({27'h0, 1'b0, progProtection, styleRamp, restoreOn, powerSetting}, wb_dat_i, wb_sel_i);
    assign powerOnWrite = wrCtl && ctlWord[ctr_pkg::CTL_POWER];
    assign alarmClear = wrCtl && ctlWord[ctr_pkg::CTL_ALARM_CLR];
    // Old contents merged with the selected bytes, so a partial write keeps the other lanes.
    assign wrWord = wbMerge(rdWord, wb_dat_i, wb_sel_i);

    // Control word; startup restores or clears the power state once after release.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            startupPending <= 1'b1;
            powerSetting <= 1'b0;
            restoreOn <= 1'b0;
            styleRamp <= ctr_pkg::STYLE_RAMP_RESET;
            progProtection <= ctr_pkg::PROG_PROT_RESET;
        end else if (startupPending) begin
            startupPending <= 1'b0;
            restoreOn <= savedRestoreOnStartup;
            powerSetting <= savedRestoreOnStartup && savedPowerSetting; // R15 R16
        end else if (wrCtl) begin
            powerSetting <= ctlWord[ctr_pkg::CTL_POWER];
            restoreOn <= ctlWord[ctr_pkg::CTL_RESTORE];
            styleRamp <= ctlWord[ctr_pkg::CTL_STYLE_RAMP];
            progProtection <= ctlWord[ctr_pkg::CTL_PROG_PROT];
        end else if (tripExpire) begin
            powerSetting <= 1'b0; // R8
        end
    end

    // Setpoint, limit, rate and trip registers.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            vset0 <= '0;
            vset1 <= '0;
            ilim0 <= 16'h0000;
            ilim1 <= 16'h0000;
            currentSetting <= 16'h0000;
            rampUp <= ctr_pkg::RAMP_RESET;
            rampDown <= ctr_pkg::RAMP_RESET;
            tripLimit <= ctr_pkg::TRIP_LIMIT_RESET;
        end else if (busTake && wb_we_i) begin
            case (wb_adr_i)
                ctr_pkg::OFS_VSET0: vset0 <= wrWord[VW-1:0];
                ctr_pkg::OFS_VSET1: vset1 <= wrWord[VW-1:0];
                ctr_pkg::OFS_ILIM0: ilim0 <= wrWord[15:0];
                ctr_pkg::OFS_ILIM1: ilim1 <= wrWord[15:0];
                ctr_pkg::OFS_CURR_SETTING: currentSetting <= wrWord[15:0];
                ctr_pkg::OFS_RAMP_UP: rampUp <= wrWord[15:0];
                ctr_pkg::OFS_RAMP_DOWN: rampDown <= wrWord[15:0];
                ctr_pkg::OFS_TRIP_LIMIT: tripLimit <= wrWord[9:0];
                default: ;
            endcase
        end
    end

    // Read mux; unmapped addresses answer with zero.
    always_comb begin
        case (wb_adr_i)
            ctr_pkg::OFS_CONTROL: rdWord = {28'h0, progProtection, styleRamp, restoreOn, powerSetting};
            ctr_pkg::OFS_VSET0: rdWord = 32'(vset0);
            ctr_pkg::OFS_VSET1: rdWord = 32'(vset1);
            ctr_pkg::OFS_ILIM0: rdWord = {16'h0, ilim0};
            ctr_pkg::OFS_ILIM1: rdWord = {16'h0, ilim1};
            ctr_pkg::OFS_CURR_SETTING: rdWord = {16'h0, currentSetting};
            ctr_pkg::OFS_RAMP_UP: rdWord = {16'h0, rampUp};
            ctr_pkg::OFS_RAMP_DOWN: rdWord = {16'h0, rampDown};
            ctr_pkg::OFS_TRIP_LIMIT: rdWord = {22'h0, tripLimit};
            ctr_pkg::OFS_STATUS: rdWord = {27'h0, killHold, ramping, tripped, overCurrent, channelOn};
            ctr_pkg::OFS_OUT_SETPOINT: rdWord = 32'(outputSetpoint);
            ctr_pkg::OFS_VOLT_READBACK: rdWord = 32'(voltageReadback);
            ctr_pkg::OFS_CURR_READBACK: rdWord = {16'h0, currentReadback};
            default: rdWord = 32'h0000_0000;
        endcase
    end

    // Single-cycle acknowledge, dropped the cycle after it is given.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= busTake;
            wb_dat_o <= (busTake && !wb_we_i) ? rdWord : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Tick divider
    // ------------------------------------------------------------
    logic [$clog2(TICK_CYCLES)-1:0] tickCount;
    logic tick;

    // A one-cycle enable every tick period paces ramps and the trip count.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            tickCount <= '0;
            tick <= 1'b0;
        end else begin
            tick <= tickCount == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1); // R21
            tickCount <= (tickCount == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1)) ? '0 : tickCount + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Overcurrent and trip counter
    // ------------------------------------------------------------
    logic [9:0] tripCount;

    // Fixed protection only compares against the nominal setting and never regulates.
    assign overCurrent = channelOn && (progProtection ? currentReadback >= activeCurrentLimit
                                                      : currentReadback > currentSetting); // R7
    assign tripExpire = tick && overCurrent && isTripMode(tripLimit) && tripCount == 10'h001; // R8 R11

    // Reload has priority over counting; a limit of 1000 never counts.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            tripCount <= ctr_pkg::TRIP_LIMIT_RESET;
        end else if (wrTrip || alarmClear || powerOnWrite || !overCurrent) begin
            tripCount <= wrTrip ? wrWord[9:0] : tripLimit; // R10 R14
        end else if (tick && isTripMode(tripLimit) && tripCount != 10'h000) begin
            tripCount <= tripCount - 10'h001; // R11 R5
        end
    end

    // Tripped flag: expiry wins over a clear arriving in the same cycle.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            tripped <= 1'b0;
            killHold <= 1'b0;
        end else if (tripExpire) begin
            tripped <= 1'b1; // R23
            killHold <= !styleRamp; // R9 R17
        end else if (alarmClear || powerOnWrite) begin
            tripped <= 1'b0; // R14 R23
            killHold <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // On/off, selection and ramp
    // ------------------------------------------------------------
    logic [VW-1:0] target;
    logic [VW-1:0] steppedValue;
    logic [VW-1:0] ccValue;

    // Selected setpoint, zero when the channel is off; turn-on starts from zero.
    assign target = channelOn ? (vselActive ? vset1 : vset0) : '0; // R18 R13 R2 R4
    assign ramping = outputSetpoint != target;
    assign ccValue = (outputSetpoint > VW'(rampDown)) ? outputSetpoint - VW'(rampDown) : '0;

    ctr_ramp_step #(
        .VW(VW)
    ) rampStep (
        .current(outputSetpoint),
        .target(target),
        .upStep(rampUp),
        .downStep(rampDown),
        .nextValue(steppedValue)
    );

    // Channel state and selected current limit.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            channelOn <= 1'b0;
            activeCurrentLimit <= 16'h0000;
            powerSettingToSave <= 1'b0;
            restoreToSave <= 1'b0;
        end else begin
            channelOn <= powerSetting && !inhibitActive && enableActive && !tripped && !tripExpire; // R12
            activeCurrentLimit <= iselActive ? ilim1 : ilim0; // R19
            powerSettingToSave <= powerSetting;
            restoreToSave <= restoreOn;
        end
    end

    // Output setpoint: kill drops at once, otherwise one ramp step per tick.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            outputSetpoint <= '0;
        end else if (tripExpire && !styleRamp) begin
            outputSetpoint <= '0; // R9
        end else if (tick && overCurrent && progProtection) begin
            outputSetpoint <= ccValue; // R6 R5 R8
        end else if (tick) begin
            outputSetpoint <= steppedValue; // R1 R2 R3 R4 R20 R22
        end
    end

endmodule

`default_nettype wire

// [design/ctr_pkg.sv]
package ctr_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses, one aligned word each)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_VSET0 = 8'h04;
    localparam logic [7:0] OFS_VSET1 = 8'h08;
    localparam logic [7:0] OFS_ILIM0 = 8'h0C;
    localparam logic [7:0] OFS_ILIM1 = 8'h10;
    localparam logic [7:0] OFS_RAMP_UP = 8'h14;
    localparam logic [7:0] OFS_RAMP_DOWN = 8'h18;
    localparam logic [7:0] OFS_TRIP_LIMIT = 8'h1C;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    localparam logic [7:0] OFS_OUT_SETPOINT = 8'h24;
    localparam logic [7:0] OFS_VOLT_READBACK = 8'h28;
    localparam logic [7:0] OFS_CURR_READBACK = 8'h2C;
    localparam logic [7:0] OFS_CURR_SETTING = 8'h30;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTL_POWER = 0;
    localparam int CTL_RESTORE = 1;
    localparam int CTL_STYLE_RAMP = 2;
    localparam int CTL_PROG_PROT = 3;
    localparam int CTL_ALARM_CLR = 4;
    localparam int STS_ON = 0;
    localparam int STS_OVERCURRENT = 1;
    localparam int STS_TRIPPED = 2;
    localparam int STS_RAMPING = 3;
    localparam int STS_KILLED = 4;

    // ------------------------------------------------------------
    // Widths, reset values and limits
    // ------------------------------------------------------------
    localparam int TRIP_W = 10;
    localparam logic [9:0] TRIP_CONSTANT_CURRENT = 10'h3E8;
    localparam logic [9:0] TRIP_LIMIT_RESET = 10'h3E8;
    localparam logic [15:0] RAMP_RESET = 16'h0032;
    localparam logic STYLE_RAMP_RESET = 1'b1;
    localparam logic PROG_PROT_RESET = 1'b1;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLOCK_PERIOD_NS = 8;
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int TICK_CYCLES = TICK_PERIOD_NS / CLOCK_PERIOD_NS;

endpackage

// [design/ctr_ramp_step.sv]
`timescale 1ns/100ps
`default_nettype none

// Moves a value one step toward its target, never overshooting.
module ctr_ramp_step #(
    parameter int VW = 24
) (
    input wire logic [VW-1:0] current,
    input wire logic [VW-1:0] target,
    input wire logic [15:0] upStep,
    input wire logic [15:0] downStep,
    output logic [VW-1:0] nextValue
);

    logic [VW:0] rise;
    logic [VW:0] fall;

    // ------------------------------------------------------------
    // Step arithmetic
    // ------------------------------------------------------------
    // One extra bit keeps the sum and difference from wrapping past the target.
    always_comb begin
        rise = {1'b0, current} + {{(VW + 1 - 16){1'b0}}, upStep};
        fall = {1'b0, current} - {{(VW + 1 - 16){1'b0}}, downStep};
        if (current < target) begin
            nextValue = (rise[VW] || rise[VW-1:0] > target) ? target : rise[VW-1:0];
        end else if (current > target) begin
            nextValue = (fall[VW] || fall[VW-1:0] < target) ? target : fall[VW-1:0];
        end else begin
            nextValue = current;
        end
    end

endmodule

`default_nettype wire

// [testbench/ctr_channel_trip_ramp_properties.sv]
`timescale 1ns/100ps
`default_nettype none

// Port-level checks of the channel block; the tick spacing check needs TICK_CYCLES of 9 or more.
module ctr_channel_trip_ramp_properties #(
    parameter int VW = 24,
    parameter int TICK_CYCLES = 10
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic externalInhibit,
    input wire logic outputEnable,
    input wire logic [VW-1:0] outputSetpoint,
    input wire logic channelOn,
    input wire logic tripped
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);

    logic take;
    logic ctlWr1;
    logic ctlWr2;
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;

    // Remembers control writes seen in the last two cycles, since a trip may only clear after one.
    always_ff @(posedge clock) begin
        ctlWr1 <= reset_n && take && wb_we_i && wb_adr_i == ctr_pkg::OFS_CONTROL;
        ctlWr2 <= reset_n && ctlWr1;
    end

    a_ack_next_cycle: assert property (take |=> wb_ack_o) else $error("ack missing after request");
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
    a_idle_data_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data not zero");
    a_inhibit_blocks_on: assert property (externalInhibit [*4] |-> !channelOn) else $error("on under inhibit");
    a_disable_blocks_on: assert property (!outputEnable [*4] |-> !channelOn) else $error("on while off");
    a_off_no_rise: assert property (!channelOn && !$past(channelOn) |-> outputSetpoint <= $past(outputSetpoint))
        else $error("setpoint rose while off");
    a_tick_spacing: assert property ($changed(outputSetpoint) |-> ##2 $stable(outputSetpoint) [*7])
        else $error("setpoint moved between ticks");
    a_trip_drops_on: assert property ($rose(tripped) |-> ##[0:2] !channelOn) else $error("trip kept on");
    a_trip_blocks_on: assert property (tripped [*2] |-> !channelOn) else $error("on while tripped");
    a_trip_sticky: assert property ($fell(tripped) |-> ctlWr1 || ctlWr2) else $error("trip cleared alone");

    c_trip: cover property ($rose(tripped));
    c_turn_on: cover property ($rose(channelOn));
    c_plain_off: cover property ($fell(channelOn) && !tripped);
endmodule

bind ctr_channel_trip_ramp ctr_channel_trip_ramp_properties #(.VW(VW), .TICK_CYCLES(TICK_CYCLES)) u_props (
    .clock(clock), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .externalInhibit(externalInhibit),
    .outputEnable(outputEnable), .outputSetpoint(outputSetpoint), .channelOn(channelOn), .tripped(tripped));

`default_nettype wire

// [testbench/ctr_channel_trip_ramp_tb.sv]
`timescale 1ns/100ps
`default_nettype none

module ctr_channel_trip_ramp_tb;
    localparam int TK = 10;
    localparam int UP = 40;
    localparam int DN = 30;
    logic clock, reset_n, cyc, stb, we, inhibit, enable, voltage_setpoint_select, current_limit_select, savedP, savedR, overload, killOk;
    logic ack, chOn, trip, pSave, rSave;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] datI, datO;
    logic [23:0] outSet, vRb, prevSet;
    logic [15:0] actLim, iRb;
    int error_cnt, cmp_count;

    ctr_channel_trip_ramp #(.VW(24), .TICK_CYCLES(TK)) dut (.clock(clock), .reset_n(reset_n),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI),
        .wb_dat_o(datO), .wb_ack_o(ack), .externalInhibit(inhibit), .outputEnable(enable),
        .voltageSetpointSelect(voltage_setpoint_select), .currentLimitSelect(current_limit_select), .voltageReadback(vRb), .currentReadback(iRb),
        .savedPowerSetting(savedP), .savedRestoreOnStartup(savedR), .outputSetpoint(outSet),
        .activeCurrentLimit(actLim), .channelOn(chOn), .tripped(trip), .powerSettingToSave(pSave),
        .restoreToSave(rSave));

    ctr_output_stage #(.VW(24), .KNEE(150)) stage (.clock(clock), .outputSetpoint(outSet), .overload(overload),
        .voltageReadback(vRb), .currentReadback(iRb));

    // Free-running 125 MHz clock.
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task automatic end_of_test();
        if (error_cnt == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic fail(input string msg);
        error_cnt++;
        $display("[FAIL] %0t %s", $time, msg);
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) fail($sformatf("got %h expected %h", got, exp));
    endtask

    // One classic cycle: hold everything until ack is sampled, then release for a cycle.
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        datI <= d;
        do begin
            @(posedge clock);
            n++;
        end while (ack !== 1'b1 && n < 50);
        r = datO;
        if (n >= 50) fail("no bus answer");
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clock);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        wb(a, 1'b1, d, r);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        wb(a, 1'b0, 32'h0, r);
        check(r, exp);
    endtask

    task automatic ticks(input int n);
        repeat (n * TK) @(posedge clock);
    endtask

    task automatic waitSet(input logic [31:0] v);
        int n;
        n = 0;
        while (32'(outSet) !== v && n < 3000) begin
            @(posedge clock);
            n++;
        end
        check(32'(outSet), v);
    endtask

    task automatic rst(input logic p, input logic r);
        savedP <= p;
        savedR <= r;
        reset_n <= 1'b0;
        repeat (5) @(posedge clock);
        reset_n <= 1'b1;
        repeat (3) @(posedge clock);
    endtask

    // Every setpoint move stays within the programmed step; only a kill trip may drop straight to zero.
    always @(posedge clock) begin
        if (reset_n && outSet > prevSet && outSet - prevSet > 24'(UP)) fail("rise too fast");
        if (reset_n && outSet < prevSet && prevSet - outSet > 24'(DN) && !(killOk && outSet == 24'h0))
            fail("fall too fast");
        prevSet <= outSet;
    end

    // Cuts a hang short well beyond the expected run length.
    initial begin
        repeat (40000) @(posedge clock);
        error_cnt++;
        end_of_test();
    end

    initial begin
        {reset_n, cyc, stb, we, inhibit, voltage_setpoint_select, current_limit_select, savedP, savedR, overload, killOk} = '0;
        enable = 1'b1;
        adr = 8'h00;
        sel = 4'hF;
        datI = 32'h0;
        prevSet = 24'h0;
        error_cnt = 0;
        cmp_count = 0;
        rst(1'b0, 1'b0);
        rd(ctr_pkg::OFS_CONTROL, 32'h0000000C);
        rd(ctr_pkg::OFS_RAMP_UP, 32'h00000032);
        rd(ctr_pkg::OFS_RAMP_DOWN, 32'h00000032);
        rd(ctr_pkg::OFS_TRIP_LIMIT, 32'h000003E8);
        wr(8'hFC, 32'hFFFFFFFF);
        rd(8'hFC, 32'h0);
        wr(ctr_pkg::OFS_VSET0, 32'h64);
        wr(ctr_pkg::OFS_VSET1, 32'h12C);
        wr(ctr_pkg::OFS_ILIM0, 32'h1F4);
        wr(ctr_pkg::OFS_ILIM1, 32'h2BC);
        wr(ctr_pkg::OFS_RAMP_UP, 32'(UP));
        wr(ctr_pkg::OFS_RAMP_DOWN, 32'(DN));
        wr(ctr_pkg::OFS_CURR_SETTING, 32'h100);
        check(32'(actLim), 32'h1F4);
        current_limit_select <= 1'b1;
        inhibit <= 1'b1;
        repeat (5) @(posedge clock);
        check(32'(actLim), 32'h2BC);
        current_limit_select <= 1'b0;
        wr(ctr_pkg::OFS_CONTROL, 32'h0D);
        ticks(3);
        check(32'(chOn), 32'h0);
        check(32'(outSet), 32'h0);
        inhibit <= 1'b0;
        waitSet(32'h64);
        voltage_setpoint_select <= 1'b1;
        waitSet(32'h12C);
        voltage_setpoint_select <= 1'b0;
        waitSet(32'h64);
        voltage_setpoint_select <= 1'b1;
        waitSet(32'h12C);
        enable <= 1'b0;
        waitSet(32'h0);
        check(32'(chOn), 32'h0);
        enable <= 1'b1;
        waitSet(32'h12C);
        overload <= 1'b1;
        ticks(40);
        check({trip, chOn, outSet < 24'h12C}, 32'h3);
        overload <= 1'b0;
        waitSet(32'h12C);
        wr(ctr_pkg::OFS_TRIP_LIMIT, 32'h5);
        wr(ctr_pkg::OFS_CONTROL, 32'h05);
        overload <= 1'b1;
        ticks(3);
        check(32'(outSet), 32'h12C);
        overload <= 1'b0;
        ticks(1);
        overload <= 1'b1;
        ticks(3);
        check(32'(trip), 32'h0);
        ticks(3);
        check({trip, chOn}, 32'h2);
        waitSet(32'h0);
        overload <= 1'b0;
        rd(ctr_pkg::OFS_CONTROL, 32'h04);
        ticks(3);
        check(32'(trip), 32'h1);
        wr(ctr_pkg::OFS_CONTROL, 32'h14);
        check(32'(trip), 32'h0);
        wr(ctr_pkg::OFS_CONTROL, 32'h01);
        waitSet(32'h12C);
        killOk <= 1'b1;
        overload <= 1'b1;
        ticks(7);
        repeat (2) @(posedge clock);
        check({trip, outSet}, 32'h01000000);
        rd(ctr_pkg::OFS_STATUS, 32'h00000014);
        overload <= 1'b0;
        wr(ctr_pkg::OFS_CONTROL, 32'h01);
        killOk <= 1'b0;
        check(32'(trip), 32'h0);
        waitSet(32'h12C);
        rd(ctr_pkg::OFS_OUT_SETPOINT, 32'h0000012C);
        rd(ctr_pkg::OFS_VOLT_READBACK, 32'h0000012C);
        wr(ctr_pkg::OFS_CONTROL, 32'h00);
        ticks(2);
        check(32'(outSet != 24'h0), 32'h1);
        waitSet(32'h0);
        rst(1'b1, 1'b0);
        ticks(3);
        check({chOn, pSave}, 32'h0);
        rst(1'b1, 1'b1);
        ticks(1);
        check({chOn, pSave, rSave}, 32'h7);
        end_of_test();
    end
endmodule

`default_nettype wire

// [testbench/ctr_output_stage.sv]
`timescale 1ns/100ps
`default_nettype none

module ctr_output_stage #(
    parameter int VW = 24,
    parameter int KNEE = 150
) (
    input wire logic clock,
    input wire logic [VW-1:0] outputSetpoint,
    input wire logic overload,
    output logic [VW-1:0] voltageReadback,
    output logic [15:0] currentReadback
);
    // The supply follows its setpoint a cycle late; an overloaded load draws heavily only above a knee,
    // so regulation can settle instead of collapsing the output to zero.
    always_ff @(posedge clock) begin
        voltageReadback <= outputSetpoint;
        currentReadback <= (overload && outputSetpoint > VW'(KNEE)) ? 16'hFFFF : 16'h0010;
    end
endmodule

`default_nettype wire
